// [verilog/fcs_pkg.sv]
// Shared constants and carrier types of the flash command and status unit
package fcs_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [13:0] IDX_COMMAND_CODE = 14'h1826;
  localparam logic [13:0] IDX_PROGRAM_STATUS = 14'h1830;
  localparam logic [13:0] IDX_TARGET_ADDR = 14'h1831;
  localparam logic [13:0] IDX_TARGET_DATA = 14'h1832;
  localparam logic [13:0] IDX_CLOCK_DIV = 14'h1833;
  localparam logic [13:0] IDX_PROTECT = 14'h1834;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h1835;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h1836;

  // Program status bit positions
  localparam int ST_CBEF = 7;
  localparam int ST_CCF = 6;
  localparam int ST_PVIOL = 5;
  localparam int ST_ACCERR = 4;
  localparam int ST_BLANK = 2;

  // Interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACCERR = 1;
  localparam int IRQ_PVIOL = 2;
  localparam int IRQ_BUF_EMPTY = 3;

  // Protect register layout: boundary in [7:1], disable in [0]
  localparam int PROT_DIS = 0;
  localparam logic [7:0] PROTECT_RESET = 8'h01;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [15:0] PAGE_MASK = 16'hfe00;

  // Command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
  localparam logic [7:0] CMD_BURST_PROG = 8'h25;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;

  typedef enum logic [1:0]
  {
    FCS_IDLE = 2'b01,
    FCS_RUN = 2'b10
  } fcs_state_t;

  // One array operation handed to the flash array
  typedef struct packed
  {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
  } fcs_arr_req_t;
endpackage : fcs_pkg

// [verilog/fcs_flash_cmd_status.sv]
// Flash command launch, status flags and APB register file
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Writing one to buffer empty launches and clears it; sets when the command reaches array.
// - Only burst program may be queued, and only while a previous burst program runs.
// - Complete flag is set when buffer empty and idle, cleared on launch.
// - Program or erase hitting a protected location sets violation and is discarded.
// - Violation flag clears only by software writing one to it.
// - Bad sequence, unset divider on program or erase, or stop mid-command set access error.
// - Access error clears by writing one; writing zero leaves it.
// - Blank flag set after blank check only if whole array reads erased.
// - Blank flag clears on a new valid launch; writes do not affect it.
// - Status bits three, one and zero read zero; writes ignored.
// - Command register is write-only, resets to zero, reads zero.
// - Five command codes accepted: blank, byte, burst, page and mass erase.
// - Page erase clears one 512-byte page; mass erase clears everything.
// - Any other command code is illegal and raises access error.
// - Protected locations are never programmed or erased.
module fcs_flash_cmd_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_req,
  input wire logic arr_done,
  input wire logic arr_blank,
  output fcs_pkg::fcs_arr_req_t arr_req,
  output logic arr_start,
  output logic arr_abort,
  output logic [7:0] prog_div,
  output logic irq
);
  fcs_pkg::fcs_state_t state_reg, state_next;
  logic [7:0] cmd_reg;
  logic [15:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] div_reg;
  logic div_set_reg;
  logic [7:0] prot_reg;
  logic cmd_written_reg;
  logic cbef_reg, pviol_reg, accerr_reg, blank_reg;
  logic pending_reg;
  fcs_pkg::fcs_arr_req_t pend_req_reg, cur_req_reg;
  logic [3:0] irq_stat_reg, irq_mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg, irq_reg;
  logic arr_start_reg, arr_abort_reg;
  logic [2:0] stop_sync_reg;
  logic stop_seen_reg;
  logic ccf_prev_reg, cbef_prev_reg;

  // Word index decode
  function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
    hit = (a[15:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit

  function automatic logic legal_cmd(input logic [7:0] c);
    legal_cmd = (c == fcs_pkg::CMD_BLANK) || (c == fcs_pkg::CMD_BYTE_PROG) ||
      (c == fcs_pkg::CMD_BURST_PROG) || (c == fcs_pkg::CMD_PAGE_ERASE) ||
      (c == fcs_pkg::CMD_MASS_ERASE);
  endfunction : legal_cmd

  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pready_reg && pwrite;
  wire rd_acc = psel && penable && pready_reg && !pwrite;
  wire sel_cmd = hit(paddr, fcs_pkg::IDX_COMMAND_CODE);
  wire sel_stat = hit(paddr, fcs_pkg::IDX_PROGRAM_STATUS);
  wire sel_addr = hit(paddr, fcs_pkg::IDX_TARGET_ADDR);
  wire sel_data = hit(paddr, fcs_pkg::IDX_TARGET_DATA);
  wire sel_div = hit(paddr, fcs_pkg::IDX_CLOCK_DIV);
  wire sel_prot = hit(paddr, fcs_pkg::IDX_PROTECT);
  wire sel_istat = hit(paddr, fcs_pkg::IDX_IRQ_STATUS);
  wire sel_imask = hit(paddr, fcs_pkg::IDX_IRQ_MASK);
  wire mapped = sel_cmd || sel_stat || sel_addr || sel_data || sel_div ||
    sel_prot || sel_istat || sel_imask;

  wire busy = (state_reg == fcs_pkg::FCS_RUN);
  // Complete flag is derived, so it never disagrees with the queue
  wire ccf = cbef_reg && !pending_reg && !busy;

  wire stat_wr = wr_acc && sel_stat;
  // Launch only by writing one while the buffer is empty
  wire launch = stat_wr && pwdata[fcs_pkg::ST_CBEF] && cbef_reg;
  wire is_blank = (cmd_reg == fcs_pkg::CMD_BLANK);
  wire is_burst = (cmd_reg == fcs_pkg::CMD_BURST_PROG);
  wire is_mass = (cmd_reg == fcs_pkg::CMD_MASS_ERASE);
  wire is_pe = legal_cmd(cmd_reg) && !is_blank;
  // Launch during execution is legal only for burst behind burst
  wire seq_bad = !cmd_written_reg ||
    (busy && !(is_burst && cur_req_reg.cmd == fcs_pkg::CMD_BURST_PROG));
  // High end above the boundary is protected; mass erase always hits it
  wire in_prot = !prot_reg[fcs_pkg::PROT_DIS] &&
    (is_mass || (addr_reg[15:9] > prot_reg[7:1]));
  wire acc_bad = launch && (seq_bad || !legal_cmd(cmd_reg) ||
    (is_pe && !div_set_reg));
  wire prot_bad = launch && !acc_bad && is_pe && in_prot;
  wire good_launch = launch && !acc_bad && !prot_bad;

  // Stop level agreed by the second and third synchroniser stages
  wire stop_now = stop_sync_reg[1] && stop_sync_reg[2];
  wire stop_abort = stop_now && !stop_seen_reg && (busy || pending_reg);

  // Queued command moves to the array once the array is free
  wire xfer = pending_reg && !stop_abort && (!busy || arr_done);
  wire finish = busy && arr_done && !xfer;

  // Page erase works on the 512-byte page holding the address
  wire [15:0] launch_addr = (cmd_reg == fcs_pkg::CMD_PAGE_ERASE) ?
    (addr_reg & fcs_pkg::PAGE_MASK) : (is_mass ? 16'h0000 : addr_reg);

  wire [7:0] stat_view = {cbef_reg, ccf, pviol_reg, accerr_reg, 1'b0,
    blank_reg, 2'b00};
  wire [7:0] rd_byte = sel_stat ? stat_view :
    sel_addr ? addr_reg[7:0] :
    sel_data ? data_reg :
    sel_div ? div_reg :
    sel_prot ? prot_reg :
    sel_istat ? {4'h0, irq_stat_reg} :
    sel_imask ? {4'h0, irq_mask_reg} : 8'h00;
  wire [15:0] rd_hi = sel_addr ? {8'h00, addr_reg[15:8]} : 16'h0000;

  wire [3:0] irq_ev = {cbef_reg && !cbef_prev_reg, prot_bad,
    acc_bad || stop_abort, ccf && !ccf_prev_reg};
  wire istat_rd = rd_acc && sel_istat;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      fcs_pkg::FCS_IDLE: if (xfer) state_next = fcs_pkg::FCS_RUN;
      fcs_pkg::FCS_RUN:
        if (stop_abort || finish) state_next = fcs_pkg::FCS_IDLE;
      default: state_next = fcs_pkg::FCS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_sync_reg <= 3'h0;
      stop_seen_reg <= 1'b0;
      state_reg <= fcs_pkg::FCS_IDLE;
    end
    else
    begin
      stop_sync_reg <= {stop_sync_reg[1:0], stop_req};
      stop_seen_reg <= stop_now;
      state_reg <= state_next;
    end
  end

  // APB answer: data captured in setup, one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= (setup && !pwrite) ? {rd_hi, 8'h00, rd_byte} : 32'h0;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_reg <= fcs_pkg::COMMAND_RESET;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
      div_reg <= 8'h00;
      div_set_reg <= 1'b0;
      prot_reg <= fcs_pkg::PROTECT_RESET;
      irq_mask_reg <= 4'h0;
    end
    else
    begin
      if (wr_acc && sel_cmd) cmd_reg <= pwdata[7:0];
      if (wr_acc && sel_addr) addr_reg <= pwdata[15:0];
      if (wr_acc && sel_data) data_reg <= pwdata[7:0];
      if (wr_acc && sel_div) div_reg <= pwdata[7:0];
      if (wr_acc && sel_div) div_set_reg <= 1'b1;
      if (wr_acc && sel_prot) prot_reg <= pwdata[7:0];
      if (wr_acc && sel_imask) irq_mask_reg <= pwdata[3:0];
    end
  end

  // A command write arms the next launch; any launch attempt consumes it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) cmd_written_reg <= 1'b0;
    else if (wr_acc && sel_cmd) cmd_written_reg <= 1'b1;
    else if (launch) cmd_written_reg <= 1'b0;
  end

  // Status flags; for violation and access error, hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cbef_reg <= 1'b1;
      pviol_reg <= 1'b0;
      accerr_reg <= 1'b0;
      blank_reg <= 1'b0;
    end
    else
    begin
      // Cleared by a good launch, set again on transfer or abort
      if (good_launch) cbef_reg <= 1'b0;
      else if (xfer || stop_abort) cbef_reg <= 1'b1;
      // Set by hardware, cleared only by a written one
      if (prot_bad) pviol_reg <= 1'b1;
      else if (stat_wr && pwdata[fcs_pkg::ST_PVIOL]) pviol_reg <= 1'b0;
      // Set by hardware, a written zero has no effect
      if (acc_bad || stop_abort) accerr_reg <= 1'b1;
      else if (stat_wr && pwdata[fcs_pkg::ST_ACCERR]) accerr_reg <= 1'b0;
      // Only the array result or a new launch moves it
      if (good_launch) blank_reg <= 1'b0;
      else if (busy && arr_done && cur_req_reg.cmd == fcs_pkg::CMD_BLANK)
        blank_reg <= arr_blank;
    end
  end

  // Command queue and array handshake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_reg <= 1'b0;
      pend_req_reg <= '0;
      cur_req_reg <= '0;
      arr_start_reg <= 1'b0;
      arr_abort_reg <= 1'b0;
    end
    else
    begin
      arr_start_reg <= xfer;
      arr_abort_reg <= stop_abort;
      if (good_launch)
      begin
        pending_reg <= 1'b1;
        pend_req_reg <= '{cmd: cmd_reg, addr: launch_addr, data: data_reg};
      end
      else if (xfer || stop_abort)
        pending_reg <= 1'b0;
      if (xfer) cur_req_reg <= pend_req_reg;
    end
  end

  // Interrupt status clears on read; a new event in that cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_reg <= 4'h0;
      irq_reg <= 1'b0;
      ccf_prev_reg <= 1'b1;
      cbef_prev_reg <= 1'b1;
    end
    else
    begin
      irq_stat_reg <= (istat_rd ? 4'h0 : irq_stat_reg) | irq_ev;
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
      ccf_prev_reg <= ccf;
      cbef_prev_reg <= cbef_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign arr_req = cur_req_reg;
  assign arr_start = arr_start_reg;
  assign arr_abort = arr_abort_reg;
  assign prog_div = div_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  launch_clears_cbef_a: assert property (
    good_launch |=> !cbef_reg ##1 (cbef_reg || pending_reg))
    else $error("buffer empty flag wrong after launch");
  queue_burst_only_a: assert property (
    (launch && busy && !is_burst) |=> accerr_reg && !pending_reg)
    else $error("non-burst command queued behind a running one");
  complete_flag_a: assert property (
    good_launch |=> !ccf)
    else $error("complete flag stayed set after launch");
  protect_discard_a: assert property (
    prot_bad |=> pviol_reg && !pending_reg ##1 !arr_start_reg)
    else $error("protected command not discarded");
  pviol_hold_a: assert property (
    (pviol_reg && !(stat_wr && pwdata[fcs_pkg::ST_PVIOL])) |=> pviol_reg)
    else $error("violation flag cleared without a written one");
  div_missing_a: assert property (
    (launch && is_pe && !div_set_reg) |=> accerr_reg && !pending_reg)
    else $error("program or erase accepted before divider set");
  accerr_zero_a: assert property (
    (accerr_reg && stat_wr && !pwdata[fcs_pkg::ST_ACCERR]) |=> accerr_reg)
    else $error("access error cleared by a written zero");
  blank_result_a: assert property (
    (busy && arr_done && cur_req_reg.cmd == fcs_pkg::CMD_BLANK && !xfer)
      |=> (blank_reg == $past(arr_blank)) && ccf)
    else $error("blank flag does not match array result");
  blank_clear_a: assert property (
    good_launch |=> !blank_reg)
    else $error("blank flag not cleared on launch");
  reserved_zero_a: assert property (
    (setup && !pwrite && sel_stat) |=> prdata[3] == 1'b0 &&
      prdata[1:0] == 2'b00)
    else $error("reserved status bits read nonzero");
  cmd_reads_zero_a: assert property (
    (setup && !pwrite && sel_cmd) |=> prdata == 32'h0)
    else $error("command register read nonzero");
  illegal_code_a: assert property (
    (launch && !legal_cmd(cmd_reg)) |=> accerr_reg)
    else $error("illegal command not flagged");

  burst_queued_c: cover property (launch && busy && good_launch);
  blank_pass_c: cover property (blank_reg && ccf);
  protect_hit_c: cover property (prot_bad);
  stop_abort_c: cover property (stop_abort);
endmodule : fcs_flash_cmd_status

`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the flash command and status unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, stop_req = 1'b0, arr_done = 1'b0;
  logic arr_blank = 1'b0, blank_in = 1'b0, serr;
  logic pready, pslverr, arr_start, arr_abort, irq;
  logic [15:0] paddr = 16'h0000, rnd = 16'ha897, a;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] prog_div, c, d;
  logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  fcs_pkg::fcs_arr_req_t arr_req, last_req;
  int err_total = 0, tests_run = 0, lat = 3, cnt = 0, starts = 0, n0;
  always #4 pclk = ~pclk;
  fcs_flash_cmd_status uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_req, .arr_done,
    .arr_blank, .arr_req, .arr_start, .arr_abort, .prog_div, .irq);
  // Array stand-in: answers each start after lat cycles
  always @(posedge pclk)
  begin
    arr_done <= 1'b0;
    arr_blank <= ~arr_blank;
    if (arr_start === 1'b1)
    begin
      last_req <= arr_req;
      starts <= starts + 1;
      cnt <= lat;
    end
    else if (arr_abort === 1'b1)
      cnt <= 0;
    else if (cnt == 1)
    begin
      arr_done <= 1'b1;
      arr_blank <= blank_in;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] xst(input logic pv, ae, bl);
    return {2'b11, pv, ae, 1'b0, bl, 2'b00};
  endfunction : xst
  function automatic logic prot(input logic [7:0] k, input logic [15:0] ad,
    input logic [7:0] pr);
    return !pr[0] && k != 8'h05 && (k == 8'h41 || ad[15:9] > pr[7:1]);
  endfunction : prot
  function automatic logic [15:0] xaddr(input logic [7:0] k,
    input logic [15:0] ad);
    return k == 8'h41 ? 16'h0000 : k == 8'h40 ? ad & 16'hfe00 : ad;
  endfunction : xaddr
  task print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task tmo;
    err_total++;
    $display("wrong value at %0t: wait ran out", $time);
    print_verdict;
  endtask : tmo
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      tmo;
  endtask : apb
  task rs;
    apb(1'b0, fcs_pkg::IDX_PROGRAM_STATUS, 32'h0);
  endtask : rs
  task st(input logic [7:0] v);
    apb(1'b1, fcs_pkg::IDX_PROGRAM_STATUS, {24'h0, v});
  endtask : st
  task launch(input logic [7:0] k, input logic [15:0] ad,
    input logic [7:0] dt);
    // Address, data and code first, then the launch write
    apb(1'b1, fcs_pkg::IDX_TARGET_ADDR, {16'h0, ad});
    apb(1'b1, fcs_pkg::IDX_TARGET_DATA, {24'h0, dt});
    apb(1'b1, fcs_pkg::IDX_COMMAND_CODE, {24'h0, k});
    st(8'h80);
  endtask : launch
  task wait_cc;
    int n;
    n = 0;
    do
    begin
      rs;
      n++;
    end
    while (rd[6] !== 1'b1 && n < 200);
    if (n >= 200)
      tmo;
  endtask : wait_cc
  initial
  begin
    #400000;
    tmo;
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rs;
    chk(rd, 32'hc0);
    apb(1'b0, fcs_pkg::IDX_COMMAND_CODE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 14'h1837, 32'h0);
    chk({31'h0, serr}, 32'h1);
    launch(8'h20, 16'h0100, 8'h5a);
    rs;
    chk(rd, xst(0, 1, 0));
    chk(starts, 0);
    st(8'h00);
    rs;
    chk(rd, xst(0, 1, 0));
    st(8'h10);
    rs;
    chk(rd, 32'hc0);
    apb(1'b1, fcs_pkg::IDX_CLOCK_DIV, 32'h13);
    st(8'h80);
    rs;
    chk(rd, xst(0, 1, 0));
    st(8'h10);
    $display("done: reset and early errors");
    // Mass erase comes last and is not followed by a blank check
    for (int i = 0; i < 5; i++)
    begin
      rnd = lfsr(rnd);
      a = rnd;
      rnd = lfsr(rnd);
      d = rnd[7:0];
      c = codes[i];
      blank_in = (i == 0) ? 1'b1 : rnd[8];
      lat = 1 + rnd[3:0];
      n0 = starts;
      launch(c, a, d);
      wait_cc;
      chk(rd, xst(0, 0, c == 8'h05 && blank_in));
      chk(starts, n0 + 1);
      chk({last_req.cmd, last_req.addr}, {8'h0, c, xaddr(c, a)});
      if (c == 8'h20 || c == 8'h25)
        chk(last_req.data, d);
    end
    $display("done: legal commands");
    rnd = lfsr(rnd);
    c = rnd[7:0];
    if (c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
      c = 8'h77;
    n0 = starts;
    launch(c, a, d);
    rs;
    chk(rd, xst(0, 1, 0));
    chk(starts, n0);
    st(8'h10);
    $display("done: illegal code");
    apb(1'b1, fcs_pkg::IDX_PROTECT, 32'h20);
    for (int j = 0; j < 3; j++)
    begin
      c = (j == 2) ? 8'h41 : 8'h20;
      a = (j == 0) ? 16'h3000 : 16'h1000;
      n0 = starts;
      launch(c, a, 8'h3c);
      wait_cc;
      chk(rd, xst(prot(c, a, 8'h20), 0, 0));
      chk(starts, n0 + !prot(c, a, 8'h20));
      st(8'h5f);
      rs;
      chk(rd, xst(prot(c, a, 8'h20), 0, 0));
      st(8'h20);
    end
    apb(1'b1, fcs_pkg::IDX_PROTECT, 32'h01);
    rs;
    chk(rd, 32'hc0);
    $display("done: protection");
    lat = 60;
    n0 = starts;
    launch(8'h25, 16'h0200, 8'h11);
    launch(8'h25, 16'h0201, 8'h22);
    rs;
    chk(rd[7], 1'b0);
    wait_cc;
    chk(starts, n0 + 2);
    chk(last_req.addr, 16'h0201);
    launch(8'h20, 16'h0300, 8'h33);
    launch(8'h20, 16'h0301, 8'h44);
    rs;
    chk(rd[4], 1'b1);
    wait_cc;
    st(8'h10);
    $display("done: burst queue");
    launch(8'h20, 16'h0400, 8'h55);
    stop_req <= 1'b1;
    n0 = 0;
    do
    begin
      @(posedge pclk);
      n0++;
    end
    while (arr_abort !== 1'b1 && n0 < 100);
    if (n0 >= 100)
      tmo;
    stop_req <= 1'b0;
    wait_cc;
    chk(rd, xst(0, 1, 0));
    st(8'h10);
    $display("done: stop abort");
    lat = 2;
    apb(1'b0, fcs_pkg::IDX_IRQ_STATUS, 32'h0);
    apb(1'b1, fcs_pkg::IDX_IRQ_MASK, 32'h1);
    launch(8'h20, 16'h0500, 8'h66);
    wait_cc;
    chk(irq, 1'b1);
    apb(1'b0, fcs_pkg::IDX_IRQ_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, fcs_pkg::IDX_IRQ_MASK, 32'h0);
    launch(8'h20, 16'h0501, 8'h77);
    wait_cc;
    chk(irq, 1'b0);
    chk(prog_div, 8'h13);
    $display("done: interrupts");
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
